/* pkg/drv_regs_pkg.sv */
// constants, field positions and carrier types for the driver status/config register bank
package drv_regs_pkg;

	// register addresses
	localparam logic [6:0] ADDR_GLOBAL_FLAGS = 7'h01;
	localparam logic [6:0] ADDR_WRITE_COUNT = 7'h02;
	localparam logic [6:0] ADDR_REPLY_DELAY = 7'h03;
	localparam logic [6:0] ADDR_INPUT_PINS = 7'h06;

	// global flags field positions
	localparam int FAULT_BIT = 1;
	localparam int LOW_SUPPLY_BIT = 2;

	// reply delay field inside its register
	localparam int DELAY_LSB = 8;
	localparam int DELAY_W = 4;
	localparam logic [3:0] DELAY_RESET = 4'h0;
	localparam logic [6:0] DELAY_MIN_BITS = 7'h08;
	localparam logic [3:0] DELAY_MIN_SETTING = 4'h2;

	// input snapshot field positions
	localparam int PIN_ENABLE_BIT = 0;
	localparam int PIN_STANDBY_BIT = 1;
	localparam int PIN_ADDR0_BIT = 2;
	localparam int PIN_ADDR1_BIT = 3;
	localparam int PIN_DIAGNOSTIC_PIN_BIT = 4;
	localparam int PIN_STEPPER_BIT = 5;
	localparam int PIN_SERIAL_BIT = 6;
	localparam int PIN_MODE_BIT = 7;
	localparam int PIN_STEP_BIT = 8;
	localparam int PIN_DIR_BIT = 9;
	localparam int COMP_A_BIT = 10;
	localparam int COMP_B_BIT = 11;
	localparam int VERSION_LSB = 24;

	// arbitrary neutral version code
	localparam logic [7:0] VERSION_DEFAULT = 8'h5A;

	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [7:0] COUNT_ONE = 8'h01;
	localparam int SYNC_W = 13;

	// asynchronous pin levels, all active high as seen at the pin
	typedef struct packed {
		logic low_supply;
		logic coil_b_comparator;
		logic coil_a_comparator;
		logic dir;
		logic step;
		logic mode;
		logic powerdown_serial_pin;
		logic stepper;
		logic diagnostic_pin;
		logic addr_select_pin1;
		logic addr_select_pin0;
		logic standby_control_pin;
		logic enable;
	} pin_in_t;

	// one decoded register access from the serial engine
	typedef struct packed {
		logic valid;
		logic write;
		logic ok;
		logic [6:0] addr;
		logic [31:0] wdata;
	} reg_access_t;

endpackage : drv_regs_pkg

/* rtl/pin_sync.sv */
// two-flop synchroniser bank for asynchronous pin levels
`timescale 1ns/1ns
module pin_sync #(
	parameter int W = 13
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	// one two-stage chain per bit; first stage feeds only the second
	for (genvar i = 0; i < W; i++) begin : g_bit
		logic meta_q;
		logic stab_q;
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				meta_q <= 1'b0;
				stab_q <= 1'b0;
			end else begin
				meta_q <= async_in[i];
				stab_q <= meta_q;
			end
		end
		assign sync_out[i] = stab_q;
	end

endmodule : pin_sync

/* rtl/driver_status_config_regs.sv */
// status, write counter, reply delay and input snapshot registers of the driver
`timescale 1ns/1ns
module driver_status_config_regs #(
	parameter logic [7:0] VERSION_CODE = drv_regs_pkg::VERSION_DEFAULT
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire drv_regs_pkg::pin_in_t pins,
	input wire logic overtemp_active,
	input wire logic short_active,
	input wire logic shutdown_event,
	input wire drv_regs_pkg::reg_access_t access,
	output logic [31:0] rd_data,
	output logic rd_valid,
	output logic [6:0] reply_delay_bits,
	output logic power_stage_fault_flag,
	output logic [7:0] write_success_counter
);

	logic rst_meta_q; // reset release chain
	logic rst_n_q; // released reset used by all logic
	drv_regs_pkg::pin_in_t pins_s; // synchronised pin levels
	logic fault_q; // sticky power stage fault
	logic [7:0] count_q; // successful write counter
	logic [3:0] delay_cfg_q; // reply delay setting
	logic [6:0] delay_bits_q; // decoded reply delay in bit times
	logic [31:0] rd_data_q;
	logic rd_valid_q;
	logic conditions_present; // any shutdown cause still active
	logic read_flags; // read of global flags this cycle
	logic write_clear; // write-one-to-clear of fault bit
	logic good_write; // accepted write access
	logic [31:0] snapshot; // assembled input register
	logic [31:0] flags_word; // assembled global flags register
	logic [6:0] delay_bits_d;

	// reset asserts at once, releases two edges later
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	// pins come from outside the clock domain
	pin_sync #(
		.W(drv_regs_pkg::SYNC_W)
	) u_pin_sync (
		.clk(core_clk),
		.rst_n(rst_n_q),
		.async_in(pins),
		.sync_out(pins_s)
	);

	// access qualifiers; a write with bad checksum counts as failed
	assign good_write = access.valid & access.write & access.ok;
	assign read_flags = access.valid & ~access.write & access.ok
		& (access.addr == drv_regs_pkg::ADDR_GLOBAL_FLAGS);
	assign write_clear = good_write & (access.addr == drv_regs_pkg::ADDR_GLOBAL_FLAGS)
		& access.wdata[drv_regs_pkg::FAULT_BIT];
	assign conditions_present = overtemp_active | short_active;

	// sticky fault: set wins over clear, clear refused while a cause remains
	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			fault_q <= 1'b0;
		end else if (shutdown_event) begin
			fault_q <= 1'b1;
		end else if ((read_flags | write_clear) && !conditions_present) begin
			fault_q <= 1'b0;
		end
	end

	// counts only good writes; reads never touch it
	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			count_q <= drv_regs_pkg::COUNT_RESET;
		end else if (good_write) begin
			count_q <= count_q + drv_regs_pkg::COUNT_ONE;
		end
	end

	// reply delay setting, writable by a good write
	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			delay_cfg_q <= drv_regs_pkg::DELAY_RESET;
		end else if (good_write && access.addr == drv_regs_pkg::ADDR_REPLY_DELAY) begin
			delay_cfg_q <= access.wdata[drv_regs_pkg::DELAY_LSB +: drv_regs_pkg::DELAY_W];
		end
	end

	// decode: pairs share an odd multiple of eight, low pair gives the minimum
	always_comb begin
		if (delay_cfg_q < drv_regs_pkg::DELAY_MIN_SETTING) begin
			delay_bits_d = drv_regs_pkg::DELAY_MIN_BITS;
		end else begin
			delay_bits_d = {delay_cfg_q[3:1], 1'b1, 3'b000};
		end
	end

	// registered so the serial engine sees a settled count
	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			delay_bits_q <= drv_regs_pkg::DELAY_MIN_BITS;
		end else begin
			delay_bits_q <= delay_bits_d;
		end
	end

	// global flags: live supply bit beside the sticky fault
	always_comb begin
		flags_word = '0;
		flags_word[drv_regs_pkg::FAULT_BIT] = fault_q;
		flags_word[drv_regs_pkg::LOW_SUPPLY_BIT] = pins_s.low_supply;
	end

	// input snapshot; reserved bits read zero
	always_comb begin
		snapshot = '0;
		snapshot[drv_regs_pkg::PIN_ENABLE_BIT] = pins_s.enable;
		snapshot[drv_regs_pkg::PIN_STANDBY_BIT] = pins_s.standby_control_pin;
		snapshot[drv_regs_pkg::PIN_ADDR0_BIT] = pins_s.addr_select_pin0;
		snapshot[drv_regs_pkg::PIN_ADDR1_BIT] = pins_s.addr_select_pin1;
		snapshot[drv_regs_pkg::PIN_DIAGNOSTIC_PIN_BIT] = pins_s.diagnostic_pin;
		snapshot[drv_regs_pkg::PIN_STEPPER_BIT] = pins_s.stepper;
		snapshot[drv_regs_pkg::PIN_SERIAL_BIT] = pins_s.powerdown_serial_pin;
		snapshot[drv_regs_pkg::PIN_MODE_BIT] = pins_s.mode;
		snapshot[drv_regs_pkg::PIN_STEP_BIT] = pins_s.step;
		snapshot[drv_regs_pkg::PIN_DIR_BIT] = pins_s.dir;
		snapshot[drv_regs_pkg::COMP_A_BIT] = pins_s.coil_a_comparator;
		snapshot[drv_regs_pkg::COMP_B_BIT] = pins_s.coil_b_comparator;
		snapshot[drv_regs_pkg::VERSION_LSB +: 8] = VERSION_CODE;
	end

	// read mux; flags word is captured before the read clears the fault
	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rd_data_q <= '0;
			rd_valid_q <= 1'b0;
		end else begin
			rd_valid_q <= access.valid & ~access.write & access.ok;
			if (access.valid && !access.write && access.ok) begin
				unique case (access.addr)
					drv_regs_pkg::ADDR_GLOBAL_FLAGS: rd_data_q <= flags_word;
					drv_regs_pkg::ADDR_WRITE_COUNT: rd_data_q <= {24'h000000, count_q};
					drv_regs_pkg::ADDR_REPLY_DELAY: begin
						rd_data_q <= '0;
						rd_data_q[drv_regs_pkg::DELAY_LSB +: drv_regs_pkg::DELAY_W] <= delay_cfg_q;
					end
					drv_regs_pkg::ADDR_INPUT_PINS: rd_data_q <= snapshot;
					default: rd_data_q <= '0; // unmapped reads zero
				endcase
			end
		end
	end

	assign rd_data = rd_data_q;
	assign rd_valid = rd_valid_q;
	assign reply_delay_bits = delay_bits_q;
	assign power_stage_fault_flag = fault_q;
	assign write_success_counter = count_q;

endmodule : driver_status_config_regs

/* verif/status_regs_sva.sv */
// assertion checker for the driver status register bank
`timescale 1ns/1ns
module status_regs_sva #(
	parameter logic [7:0] VERSION_CODE = 8'h00
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire drv_regs_pkg::pin_in_t pins,
	input wire logic overtemp_active,
	input wire logic short_active,
	input wire logic shutdown_event,
	input wire drv_regs_pkg::reg_access_t access,
	input wire logic [31:0] rd_data,
	input wire logic rd_valid,
	input wire logic [6:0] reply_delay_bits,
	input wire logic power_stage_fault_flag,
	input wire logic [7:0] write_success_counter
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	// taken good read and good write; a bad frame must count as neither
	wire logic rd_go = access.valid && access.ok && !access.write;
	wire logic wr_go = access.valid && access.ok && access.write;
	wire logic cond = overtemp_active || short_active; // any fault still present
	a_read_answer: assert property (rd_go |=> rd_valid)
		else $error("read not answered");
	a_no_answer: assert property (!rd_go |=> !rd_valid)
		else $error("spurious read answer");
	a_count_step: assert property (wr_go |=> write_success_counter ==
		8'($past(write_success_counter) + 8'h01)) else $error("count not stepped");
	a_count_hold: assert property (!wr_go |=> $stable(write_success_counter))
		else $error("count moved");
	a_fault_set: assert property (shutdown_event |=> power_stage_fault_flag)
		else $error("fault not set");
	a_fault_keep: assert property (power_stage_fault_flag && cond |=> power_stage_fault_flag)
		else $error("fault cleared early");
	a_fault_clear: assert property (rd_go && access.addr == 7'h01 && !cond &&
		!shutdown_event |=> !power_stage_fault_flag) else $error("fault not cleared");
	a_write_clear: assert property (wr_go && access.addr == 7'h01 && access.wdata[1] &&
		!cond && !shutdown_event |=> !power_stage_fault_flag)
		else $error("fault not cleared by write");
	a_delay_code: assert property (reply_delay_bits[3:0] == 4'h8)
		else $error("delay not odd multiple of 8");
	a_version_field: assert property (rd_valid && $past(access.addr) == 7'h06 |->
		rd_data[31:24] == VERSION_CODE) else $error("bad version");
endmodule : status_regs_sva
bind driver_status_config_regs status_regs_sva #(.VERSION_CODE(VERSION_CODE)) u_sva (
	.core_clk, .arst_n, .pins, .overtemp_active, .short_active, .shutdown_event, .access,
	.rd_data, .rd_valid, .reply_delay_bits, .power_stage_fault_flag, .write_success_counter);

/* verif/host_model.sv */
// host side model issuing decoded register frames
`timescale 1ns/1ns
module host_model (
	input wire logic core_clk,
	output drv_regs_pkg::reg_access_t access
);
	initial access = '0; // quiet bus from time zero
	// one frame: raised at a falling edge, held over one rising edge, then withdrawn
	task automatic xfer(input logic w, input logic ok, input logic [6:0] a,
		input logic [31:0] d);
		@(negedge core_clk);
		access <= {1'b1, w, ok, a, d};
		@(negedge core_clk);
		access.valid <= 1'b0;
		access.wdata <= ~d; // stale data scrambled so nothing leans on it
	endtask : xfer
endmodule : host_model

/* verif/driver_status_config_regs_bench.sv */
// self-checking bench for the driver status register bank
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
	$display("Error %0t got %h exp %h", $time, a, b); end end
module driver_status_config_regs_bench;
	logic core_clk;
	logic arst_n;
	drv_regs_pkg::pin_in_t pins;
	logic overtemp_active;
	logic short_active;
	logic shutdown_event;
	drv_regs_pkg::reg_access_t access;
	logic [31:0] rd_data;
	logic rd_valid;
	logic [6:0] reply_delay_bits;
	logic power_stage_fault_flag;
	logic [7:0] write_success_counter;
	int err_count;
	int checked;
	localparam logic [7:0] VER = 8'h3C; // arbitrary version code
	driver_status_config_regs #(.VERSION_CODE(VER)) DUT (.core_clk, .arst_n, .pins,
		.overtemp_active, .short_active, .shutdown_event, .access, .rd_data, .rd_valid,
		.reply_delay_bits, .power_stage_fault_flag, .write_success_counter);
	host_model host (.core_clk, .access);
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	task automatic summarize();
		$display("compares %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : summarize
	// good read; the answer stands one cycle and is sampled there
	task automatic rd(input logic [6:0] a, output logic [31:0] q);
		host.xfer(1'b0, 1'b1, a, 32'h0);
		`CHK(rd_valid, 1'b1)
		q = rd_data;
	endtask : rd
	initial begin
		logic [31:0] q;
		arst_n = 1'b0;
		pins = '0;
		overtemp_active = 1'b0;
		short_active = 1'b0;
		shutdown_event = 1'b0;
		repeat (20) @(negedge core_clk);
		arst_n = 1'b1;
		repeat (3) @(negedge core_clk);
		`CHK(reply_delay_bits, 7'h08)
		// every delay setting, each write also counted
		for (int s = 0; s < 16; s++) begin
			host.xfer(1'b1, 1'b1, 7'h03, {20'h0, 4'(s), 8'h0});
			@(negedge core_clk);
			`CHK(reply_delay_bits, (s < 2) ? 7'h08 : 7'((s | 1) * 8))
		end
		rd(7'h03, q);
		`CHK(q, 32'h00000F00)
		host.xfer(1'b1, 1'b0, 7'h03, 32'h0); // corrupted frame
		rd(7'h02, q);
		rd(7'h02, q);
		`CHK(q[7:0], 8'h10)
		`CHK(reply_delay_bits, 7'h78)
		repeat (240) host.xfer(1'b1, 1'b1, 7'h02, 32'hFF);
		`CHK(write_success_counter, 8'h00)
		// two opposite pin patterns; pins pass two sync flops first
		for (int p = 0; p < 2; p++) begin
			pins = p ? 13'h0555 : 13'h1AAA;
			repeat (4) @(negedge core_clk);
			rd(7'h06, q);
			`CHK({q[31:24], q[11:0]}, {VER, pins[11:0]})
			rd(7'h01, q);
			`CHK(q[2], pins.low_supply)
		end
		// fault held through two refused clears, then cleared
		overtemp_active = 1'b1;
		shutdown_event = 1'b1;
		@(negedge core_clk);
		shutdown_event = 1'b0;
		for (int k = 0; k < 5; k++) begin
			rd(7'h01, q);
			// the clearing read still returns the old flag, so the third read shows 1
			`CHK(q[1], k < 3)
			`CHK(power_stage_fault_flag, k < 2)
			overtemp_active = 1'b0;
			short_active = (k == 0);
		end
		// write-one clear with no cause left, then a shutdown landing on a clearing read
		shutdown_event = 1'b1;
		@(negedge core_clk);
		shutdown_event = 1'b0;
		`CHK(power_stage_fault_flag, 1'b1)
		host.xfer(1'b1, 1'b1, 7'h01, 32'h00000002);
		`CHK(power_stage_fault_flag, 1'b0)
		fork
			rd(7'h01, q);
			begin
				@(negedge core_clk);
				shutdown_event = 1'b1;
				@(negedge core_clk);
				shutdown_event = 1'b0;
			end
		join
		`CHK(q[1], 1'b0)
		`CHK(power_stage_fault_flag, 1'b1)
		summarize();
	end
endmodule : driver_status_config_regs_bench
